// *** logic/servo_operation_mode_control.sv ***
// Purpose: Automatic and jog operation-mode control of a single positioning axis
// Assumes: Discrete inputs arrive asynchronous; move entries and parameters are on ref_clk
// Notes: Speed is in position units per clock; position counts command units
// Overview of operation
// - Command-mode digit 1 means incremental moves, otherwise absolute targets.
// - Absolute mode: positive travel is clockwise when direction digit is 1.
// - Incremental mode: same mapping, negative data turns opposite; default reverses both.
// - Travel equals position data times factor 1, 10, 100 or 1000.
// - Pause during automatic run decelerates with the running entry's deceleration time.
// - Pause again after a temporary stop resumes and finishes the remaining distance.
// - Forward and reverse starts are ignored while temporarily stopped.
// - Switching to manual while temporarily stopped discards the remaining distance.
// - Pause input is ignored during zeroing and jog.
// - Open mode select means manual; program select inputs then count as invalid.
// - Forward start held in manual jogs at jog speed with parameter 14 ramp, or parameter 40 when 14 is zero.
// - Reverse start jogs opposite to forward; direction digit 1 makes forward clockwise.
// - Jog applies the time setting held in parameter 14, or parameter 40 when 14 is zero.
`timescale 1ns/1ps
module servo_operation_mode_control (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire servo_mode_pkg::discrete_in_s terminals,
  input wire logic zeroing_busy,
  input wire servo_mode_pkg::servo_params_s params,
  input wire servo_mode_pkg::move_entry_s entry,
  output logic [servo_mode_pkg::SPEED_WIDTH-1:0] motor_speed,
  output logic rotate_cw,
  output logic signed [servo_mode_pkg::POS_WIDTH-1:0] command_position,
  output logic [servo_mode_pkg::POS_WIDTH-1:0] remaining_distance,
  output logic [15:0] active_time_constant,
  output logic [servo_mode_pkg::PROG_WIDTH-1:0] running_program,
  output logic program_select_valid,
  output logic auto_mode,
  output logic temporary_stop,
  output logic jog_active,
  output logic move_complete_output
);
  import servo_mode_pkg::*;

  function automatic logic [10:0] feed_factor(input logic [3:0] digit);
    case (digit)
      FEED_X10: feed_factor = FACTOR_10;
      FEED_X100: feed_factor = FACTOR_100;
      FEED_X1000: feed_factor = FACTOR_1000;
      default: feed_factor = FACTOR_1;
    endcase
  endfunction : feed_factor

  // Full-scale negative cannot occur: the widest product stays far below it
  function automatic logic [POS_WIDTH-1:0] magnitude(input logic signed [POS_WIDTH-1:0] v);
    magnitude = v[POS_WIDTH-1] ? POS_WIDTH'(-v) : v;
  endfunction : magnitude

  logic [SYNC_WIDTH-1:0] sync_in;
  logic [SYNC_WIDTH-1:0] sync_prev;
  mode_state_e state;
  mode_state_e next_state;
  logic move_positive;
  logic [15:0] ramp_rate;
  logic [15:0] entry_accel;
  logic [15:0] entry_decel;
  logic [SPEED_WIDTH-1:0] entry_speed;
  logic [SPEED_WIDTH-1:0] ramp_speed;
  logic [SPEED_WIDTH-1:0] target_speed;

  input_sync #(
    .WIDTH(SYNC_WIDTH)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in(terminals),
    .sync_out(sync_in)
  );

  wire fwd = sync_in[IN_FWD];
  wire rev = sync_in[IN_REV];
  wire in_auto = sync_in[IN_AUTO];
  wire fwd_rise = fwd && !sync_prev[IN_FWD];
  wire pause_rise = sync_in[IN_PAUSE] && !sync_prev[IN_PAUSE];
  wire [PROG_WIDTH-1:0] prog_sel = sync_in[IN_PROG_LSB +: PROG_WIDTH];

  // Parameter decode
  wire [3:0] mode_digit = params.command_mode[DIGIT1_LSB +: DIGIT_WIDTH];
  wire [3:0] dir_digit = params.direction_feed[DIGIT0_LSB +: DIGIT_WIDTH];
  wire [3:0] feed_digit = params.direction_feed[DIGIT1_LSB +: DIGIT_WIDTH];
  wire incremental = (mode_digit == CMD_INCREMENTAL);
  wire dir_cw = (dir_digit == DIR_CW_POSITIVE);

  // Travel of a new entry; the product is kept wide enough for 1000 times full scale
  wire signed [POS_WIDTH-1:0] data_ext = POS_WIDTH'(entry.position_data);
  wire signed [POS_WIDTH-1:0] factor_ext = POS_WIDTH'(feed_factor(feed_digit));
  wire signed [POS_WIDTH-1:0] scaled = POS_WIDTH'(data_ext * factor_ext);
  wire signed [POS_WIDTH-1:0] delta = incremental ? scaled : POS_WIDTH'(scaled - command_position);
  wire [POS_WIDTH-1:0] delta_mag = magnitude(delta);
  wire delta_positive = !delta[POS_WIDTH-1];

  // Jog time: parameter 14 when set, parameter 40 as the fallback
  wire [15:0] jog_rate = (params.accel_decel_time_setting != 16'h0000) ?
    params.accel_decel_time_setting : params.jog_time_constant;

  // Step of this cycle, clipped so the remaining distance never goes negative
  wire [POS_WIDTH-1:0] speed_ext = POS_WIDTH'(ramp_speed);
  wire auto_moving = (state == ST_AUTO_RUN) || (state == ST_PAUSE_DECEL);
  wire in_jog = (state == ST_JOG) || (state == ST_JOG_STOP);
  wire moving = auto_moving || in_jog;
  wire [POS_WIDTH-1:0] auto_step = (speed_ext > remaining_distance) ? remaining_distance : speed_ext;
  wire [POS_WIDTH-1:0] step = auto_moving ? auto_step : speed_ext;
  wire [POS_WIDTH-1:0] next_remaining = remaining_distance - (auto_moving ? auto_step : POS_ZERO);
  wire signed [POS_WIDTH-1:0] next_position = move_positive ?
    POS_WIDTH'(command_position + step) : POS_WIDTH'(command_position - step);
  wire arrived = (state == ST_AUTO_RUN) && (next_remaining == POS_ZERO);
  wire ramp_stopped = (ramp_speed == SPEED_ZERO);
  wire ramp_halt = arrived || (state == ST_IDLE) || (state == ST_PAUSED);
  // Jog stop ends only once the ramp has come down to zero
  wire jog_done = (state == ST_JOG_STOP) && ramp_stopped;

  speed_ramp u_ramp (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .halt(ramp_halt),
    .target_speed(target_speed),
    .rate(ramp_rate),
    .speed(ramp_speed)
  );

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (in_auto && fwd_rise && !zeroing_busy)
          next_state = ST_AUTO_RUN;
        else if (!in_auto && !zeroing_busy && (fwd || rev))
          next_state = ST_JOG;
      end
      ST_AUTO_RUN:
      begin
        if (arrived)
          next_state = ST_IDLE;
        else if (pause_rise)
          next_state = ST_PAUSE_DECEL;
      end
      ST_PAUSE_DECEL:
      begin
        if (next_remaining == POS_ZERO)
          next_state = ST_IDLE;
        else if (ramp_stopped)
          next_state = ST_PAUSED;
      end
      ST_PAUSED:
      begin
        // Start inputs are not looked at here
        if (!in_auto)
          next_state = ST_IDLE;
        else if (pause_rise)
          next_state = ST_AUTO_RUN;
      end
      ST_JOG:
      begin
        // Pause is not looked at while jogging
        if (!(move_positive ? fwd : rev) || in_auto)
          next_state = ST_JOG_STOP;
      end
      ST_JOG_STOP:
      begin
        if (ramp_stopped)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_comb
  begin
    target_speed = SPEED_ZERO;
    ramp_rate = entry_accel;
    case (state)
      ST_AUTO_RUN:
      begin
        target_speed = entry_speed;
        ramp_rate = entry_accel;
      end
      ST_PAUSE_DECEL: ramp_rate = entry_decel;
      ST_JOG:
      begin
        target_speed = params.jog_speed;
        ramp_rate = jog_rate;
      end
      ST_JOG_STOP: ramp_rate = jog_rate;
      default: ramp_rate = entry_accel;
    endcase
  end

  wire start_auto = (state == ST_IDLE) && (next_state == ST_AUTO_RUN);
  wire start_jog = (state == ST_IDLE) && (next_state == ST_JOG);
  wire discard = (state == ST_PAUSED) && (next_state == ST_IDLE);

  // State register and the edge-detect history
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      sync_prev <= '0;
    end
    else
    begin
      state <= next_state;
      sync_prev <= sync_in;
    end
  end

  // Entry timing and program number are caught only on an automatic start
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      running_program <= '0;
      entry_accel <= 16'h0000;
      entry_decel <= 16'h0000;
      entry_speed <= SPEED_ZERO;
    end
    else if (start_auto)
    begin
      running_program <= prog_sel;
      entry_accel <= entry.accel_time;
      entry_decel <= entry.decel_time;
      entry_speed <= entry.speed;
    end
  end

  // Direction is fixed at the start and kept through a pause
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      move_positive <= 1'b1;
    else if (start_auto)
      move_positive <= delta_positive;
    else if (start_jog)
      move_positive <= fwd;
  end

  // A discard takes the place of a step and clears only the remaining distance; the command position is kept
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      remaining_distance <= POS_ZERO;
      command_position <= POS_ZERO;
    end
    else if (start_auto)
      remaining_distance <= delta_mag;
    else if (discard)
      remaining_distance <= POS_ZERO;
    else if (moving)
    begin
      remaining_distance <= next_remaining;
      command_position <= next_position;
    end
  end

  // Set wins over clear; a start and a finish never share a cycle anyway
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      move_complete_output <= 1'b0;
    else if (arrived || jog_done)
      move_complete_output <= 1'b1;
    else if (start_auto || start_jog)
      move_complete_output <= 1'b0;
  end

  // Output stage; everything leaves through a flip-flop
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      motor_speed <= SPEED_ZERO;
      rotate_cw <= 1'b0;
      active_time_constant <= 16'h0000;
      program_select_valid <= 1'b0;
      auto_mode <= 1'b0;
      temporary_stop <= 1'b0;
      jog_active <= 1'b0;
    end
    else
    begin
      motor_speed <= ramp_speed;
      // Positive travel turns clockwise only with direction digit 1
      rotate_cw <= (move_positive == dir_cw);
      active_time_constant <= ramp_rate;
      program_select_valid <= in_auto;
      auto_mode <= in_auto;
      temporary_stop <= (state == ST_PAUSED);
      jog_active <= in_jog;
    end
  end

endmodule : servo_operation_mode_control

// *** logic/servo_mode_pkg.sv ***
// Purpose: Shared constants and types for the servo operation-mode control
// Assumes: Parameter words are four hex digits, as entered on the amplifier
// Notes: Parameter No.1 carries direction in the low digit, feed factor above it
package servo_mode_pkg;

  localparam int SYNC_WIDTH = 8;
  localparam int POS_WIDTH = 36;
  localparam int DATA_WIDTH = 24;
  localparam int SPEED_WIDTH = 16;

  // Digit fields of a parameter word
  localparam int DIGIT0_LSB = 0;
  localparam int DIGIT1_LSB = 4;
  localparam int DIGIT_WIDTH = 4;

  // Parameter No.0, second digit: command mode
  localparam logic [3:0] CMD_INCREMENTAL = 4'h1;
  // Parameter No.1, low digit: rotation direction
  localparam logic [3:0] DIR_CW_POSITIVE = 4'h1;
  // Parameter No.1, second digit: feed-length factor
  localparam logic [3:0] FEED_X1 = 4'h0;
  localparam logic [3:0] FEED_X10 = 4'h1;
  localparam logic [3:0] FEED_X100 = 4'h2;
  localparam logic [3:0] FEED_X1000 = 4'h3;

  localparam logic [10:0] FACTOR_1 = 11'h001;
  localparam logic [10:0] FACTOR_10 = 11'h00a;
  localparam logic [10:0] FACTOR_100 = 11'h064;
  localparam logic [10:0] FACTOR_1000 = 11'h3e8;

  // Bit positions of the synchronised discrete inputs
  localparam int IN_FWD = 0;
  localparam int IN_REV = 1;
  localparam int IN_PAUSE = 2;
  localparam int IN_AUTO = 3;
  localparam int IN_PROG_LSB = 4;
  localparam int PROG_WIDTH = 4;

  localparam logic [SPEED_WIDTH-1:0] SPEED_ZERO = 16'h0000;
  localparam logic [POS_WIDTH-1:0] POS_ZERO = 36'h000000000;

  typedef enum {
    ST_IDLE,
    ST_AUTO_RUN,
    ST_PAUSE_DECEL,
    ST_PAUSED,
    ST_JOG,
    ST_JOG_STOP
  } mode_state_e;

  // One point entry as handed over by the program sequencer
  typedef struct packed {
    logic signed [DATA_WIDTH-1:0] position_data;
    logic [SPEED_WIDTH-1:0] speed;
    logic [15:0] accel_time;
    logic [15:0] decel_time;
  } move_entry_s;

  // Parameter words that steer the block
  typedef struct packed {
    logic [15:0] command_mode;
    logic [15:0] direction_feed;
    logic [15:0] jog_speed;
    logic [15:0] jog_time_constant;
    logic [15:0] accel_decel_time_setting;
  } servo_params_s;

  // Discrete inputs from the terminal block, shorted to the common is high
  typedef struct packed {
    logic [PROG_WIDTH-1:0] program_number_select;
    logic auto_manual_select;
    logic pause_restart_input;
    logic reverse_start_input;
    logic forward_start_input;
  } discrete_in_s;

endpackage : servo_mode_pkg

// *** logic/input_sync.sv ***
// Purpose: Two-stage synchroniser for the discrete terminal inputs
// Assumes: Inputs are slow switch levels, no debounce needed beyond sampling
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      stage1 <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : input_sync

// *** logic/speed_ramp.sv ***
// Purpose: Linear speed ramp toward a target speed
// Assumes: Rate plus one is clock cycles per unit of speed change, zero means one unit per clock
// Notes: Halt drops speed at once; used when the motion is done, and in pause where the ramp has already stopped
`timescale 1ns/1ps
module speed_ramp (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic halt,
  input wire logic [servo_mode_pkg::SPEED_WIDTH-1:0] target_speed,
  input wire logic [15:0] rate,
  output logic [servo_mode_pkg::SPEED_WIDTH-1:0] speed
);
  import servo_mode_pkg::*;

  logic [15:0] tick_count;
  wire tick = (tick_count >= rate);
  wire rising = (speed < target_speed);
  wire falling = (speed > target_speed);
  wire [SPEED_WIDTH-1:0] speed_up = speed + 16'h0001;
  wire [SPEED_WIDTH-1:0] speed_down = speed - 16'h0001;

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || halt)
    begin
      speed <= SPEED_ZERO;
      tick_count <= 16'h0000;
    end
    else
    begin
      tick_count <= (tick || !(rising || falling)) ? 16'h0000 : tick_count + 16'h0001;
      if (tick && rising)
        speed <= speed_up;
      else if (tick && falling)
        speed <= speed_down;
    end
  end

endmodule : speed_ramp

// *** bench/servo_mode_assertions.sv ***
// Purpose: Port-level checks of the operation-mode control
// Assumes: One clock domain; bench entries use small ramp rates
// Notes: Bounded waits stay short because the bench never uses slow ramps
`timescale 1ns/1ps
module servo_mode_checker (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [15:0] motor_speed,
  input wire logic [35:0] remaining_distance,
  input wire logic [3:0] running_program,
  input wire logic program_select_valid,
  input wire logic auto_mode,
  input wire logic temporary_stop,
  input wire logic jog_active,
  input wire logic move_complete_output
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_valid_mirror; program_select_valid == auto_mode; endproperty
  a_valid_mirror: assert property (p_valid_mirror) else $error("select valid off");
  property p_manual_prog; !auto_mode |-> $stable(running_program); endproperty
  a_manual_prog: assert property (p_manual_prog) else $error("program taken in manual");
  property p_pause_hold;
    temporary_stop && $past(temporary_stop) && auto_mode
      |-> $stable(remaining_distance) && $stable(running_program);
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("paused state moved");
  property p_pause_still; temporary_stop && $past(temporary_stop) |-> motor_speed == 16'h0000; endproperty
  a_pause_still: assert property (p_pause_still) else $error("motor turns in pause");
  property p_no_pause_jog; jog_active |-> !temporary_stop; endproperty
  a_no_pause_jog: assert property (p_no_pause_jog) else $error("pause during jog");
  property p_manual_clears;
    $fell(auto_mode) && ($past(temporary_stop) || $past(temporary_stop, 2))
      |-> ##[0:2] (remaining_distance == 36'h0 && !temporary_stop);
  endproperty
  a_manual_clears: assert property (p_manual_clears) else $error("distance kept");
  property p_jog_stop_done; $fell(jog_active) |-> move_complete_output ##1 motor_speed == 16'h0000;
  endproperty
  a_jog_stop_done: assert property (p_jog_stop_done) else $error("jog stop unfinished");
  property p_jog_manual; $rose(jog_active) |-> !auto_mode && !move_complete_output; endproperty
  a_jog_manual: assert property (p_jog_manual) else $error("jog outside manual");
  property p_resume_moves;
    $fell(temporary_stop) && remaining_distance != 36'h0 |-> ##[1:60] motor_speed != 16'h0000;
  endproperty
  a_resume_moves: assert property (p_resume_moves) else $error("no restart");
  property p_done_idle; move_complete_output |-> !temporary_stop; endproperty
  a_done_idle: assert property (p_done_idle) else $error("complete while paused");
  c_pause: cover property ($rose(temporary_stop));
  c_jog: cover property ($fell(jog_active));
  c_clear: cover property ($fell(auto_mode) && $past(temporary_stop));
endmodule : servo_mode_checker

bind servo_operation_mode_control servo_mode_checker i_servo_mode_checker (.ref_clk, .sys_rst,
  .motor_speed, .remaining_distance, .running_program, .program_select_valid, .auto_mode,
  .temporary_stop, .jog_active, .move_complete_output);

// *** bench/switch_panel.sv ***
// Purpose: Terminal-block switches of the outside controller
// Assumes: Requests come from the bench as levels
// Notes: Levels change only at clock edges, like a registered controller
`timescale 1ns/1ps
module switch_panel
  import servo_mode_pkg::*;
(
  input wire logic ref_clk,
  input wire logic fwd_req,
  input wire logic rev_req,
  input wire logic pause_req,
  input wire logic auto_req,
  input wire logic [3:0] prog_req,
  output discrete_in_s terminals = '0
);
  logic [3:0] last_prog = '0;
  // A program change drops start for a cycle so the new program needs a fresh edge
  wire prog_moved = prog_req != last_prog;
  always_ff @(posedge ref_clk)
  begin
    last_prog <= prog_req;
    terminals <= {prog_req, auto_req, pause_req, rev_req, fwd_req && !prog_moved};
  end
endmodule : switch_panel

// *** bench/tb_top.sv ***
// Purpose: Self-checking bench of the operation-mode control
// Assumes: Inputs change 10 ns after the rising edge
// Notes: Each move row starts from reset so the position starts at zero
`timescale 1ns/1ps
module tb_top;
  import servo_mode_pkg::*;
  typedef struct {logic [15:0] cmd; logic [15:0] df; int data; longint pos; logic cw;} row_s;
  row_s rows [6] = '{'{16'h0000, 16'h0001, 5, 5, 1'b1}, '{16'h0000, 16'h0000, 5, 5, 1'b0},
    '{16'h0010, 16'h0011, -4, -40, 1'b0}, '{16'h0010, 16'h0020, -2, -200, 1'b1},
    '{16'h0010, 16'h0031, 2, 2000, 1'b1}, '{16'h0000, 16'h0010, -3, -30, 1'b1}};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic fwd = 1'b0;
  logic rev = 1'b0;
  logic pause = 1'b0;
  logic auto_sel = 1'b0;
  logic [3:0] prog = 4'h0;
  logic zeroing = 1'b0;
  servo_params_s params = '0;
  move_entry_s entry = '0;
  discrete_in_s terminals;
  logic [15:0] motor_speed;
  logic rotate_cw;
  logic signed [35:0] command_position;
  logic [35:0] remaining_distance;
  logic [15:0] active_time_constant;
  logic [3:0] running_program;
  logic program_select_valid;
  logic auto_mode;
  logic temporary_stop;
  logic jog_active;
  logic move_complete_output;
  int errors = 0;
  int n_compared = 0;
  switch_panel i_switch_panel (.ref_clk(ref_clk), .fwd_req(fwd), .rev_req(rev),
    .pause_req(pause), .auto_req(auto_sel), .prog_req(prog), .terminals(terminals));
  servo_operation_mode_control i_servo_operation_mode_control (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .terminals(terminals), .zeroing_busy(zeroing), .params(params),
    .entry(entry), .motor_speed(motor_speed), .rotate_cw(rotate_cw),
    .command_position(command_position), .remaining_distance(remaining_distance),
    .active_time_constant(active_time_constant), .running_program(running_program),
    .program_select_valid(program_select_valid), .auto_mode(auto_mode),
    .temporary_stop(temporary_stop), .jog_active(jog_active),
    .move_complete_output(move_complete_output));
  initial
  begin
    forever #50 ref_clk = ~ref_clk;
  end
  task results;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  task step(int n);
    repeat (n) @(posedge ref_clk);
    #10;
  endtask : step
  task chkv(logic [63:0] got, logic [63:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chkv
  task chkb(logic got, logic exp);
    chkv({63'h0, got}, {63'h0, exp});
  endtask : chkb
  function automatic logic cur(int which);
    case (which)
      0: return move_complete_output;
      1: return temporary_stop;
      2: return jog_active;
      default: return motor_speed != 16'h0000;
    endcase
  endfunction : cur
  // Bounded so a stuck state ends the run instead of hanging it
  task wait_on(int which, logic val);
    for (int i = 0; i < 5000 && cur(which) !== val; i++)
      step(1);
    if (cur(which) !== val)
    begin
      errors++;
      $display("timeout at %0t waiting on %0d", $time, which);
      results();
    end
  endtask : wait_on
  task do_reset;
    sys_rst = 1'b1;
    step(3);
    sys_rst = 1'b0;
    step(4);
  endtask : do_reset
  task tap;
    pause = 1'b1;
    step(4);
    pause = 1'b0;
  endtask : tap
  initial
  begin
    step(0);
    do_reset();
    chkb(auto_mode, 1'b0);
    chkv(64'(remaining_distance), 64'h0);
    entry = '{24'h0, 16'h0040, 16'h0000, 16'h0000};
    auto_sel = 1'b1;
    foreach (rows[k])
    begin
      params.command_mode = rows[k].cmd;
      params.direction_feed = rows[k].df;
      entry.position_data = 24'(rows[k].data);
      do_reset();
      fwd = 1'b1;
      wait_on(3, 1'b1);
      chkb(rotate_cw, rows[k].cw);
      wait_on(0, 1'b1);
      chkv(64'(command_position), 64'(rows[k].pos));
      fwd = 1'b0;
    end
    params.command_mode = 16'h0010;
    params.direction_feed = 16'h0001;
    entry = '{24'd3000, 16'h0010, 16'h0000, 16'h0002};
    prog = 4'h3;
    do_reset();
    fwd = 1'b1;
    wait_on(3, 1'b1);
    step(20);
    tap();
    step(1);
    chkv(64'(active_time_constant), 64'h2);
    wait_on(1, 1'b1);
    chkv(64'(motor_speed), 64'h0);
    fwd = 1'b0;
    prog = 4'h5;
    step(4);
    fwd = 1'b1;
    step(8);
    chkb(temporary_stop, 1'b1);
    chkv(64'(running_program), 64'h3);
    fwd = 1'b0;
    step(2);
    tap();
    wait_on(1, 1'b0);
    wait_on(0, 1'b1);
    chkv(64'(command_position), 64'd3000);
    do_reset();
    fwd = 1'b1;
    wait_on(3, 1'b1);
    step(10);
    tap();
    wait_on(1, 1'b1);
    auto_sel = 1'b0;
    fwd = 1'b0;
    step(6);
    chkv(64'(remaining_distance), 64'h0);
    chkb(move_complete_output, 1'b0);
    params.jog_speed = 16'h0010;
    params.jog_time_constant = 16'h0005;
    params.accel_decel_time_setting = 16'h0001;
    prog = 4'h2;
    step(2);
    fwd = 1'b1;
    wait_on(2, 1'b1);
    step(60);
    chkv(64'(motor_speed), 64'h10);
    chkb(rotate_cw, 1'b1);
    chkv(64'(active_time_constant), 64'h1);
    chkb(program_select_valid, 1'b0);
    tap();
    step(6);
    chkb(temporary_stop, 1'b0);
    fwd = 1'b0;
    wait_on(2, 1'b0);
    step(1);
    chkb(move_complete_output, 1'b1);
    chkv(64'(motor_speed), 64'h0);
    rev = 1'b1;
    wait_on(3, 1'b1);
    chkb(rotate_cw, 1'b0);
    rev = 1'b0;
    wait_on(2, 1'b0);
    // While zeroing runs, neither a start edge nor a pause tap may act
    zeroing = 1'b1;
    auto_sel = 1'b1;
    step(4);
    fwd = 1'b1;
    step(4);
    tap();
    step(6);
    chkv(64'(motor_speed), 64'h0);
    chkb(temporary_stop, 1'b0);
    fwd = 1'b0;
    zeroing = 1'b0;
    step(2);
    results();
  end
endmodule : tb_top
